// >>> shared/sap_consts.svh
// Register offsets, field positions and fixed values of the acquisition core
`ifndef SAP_CONSTS_SVH
`define SAP_CONSTS_SVH
`define SAP_ADDR_W 8
`define SAP_REG_CTRL 8'h00
`define SAP_REG_AVG 8'h04
`define SAP_REG_CUTOFF 8'h08
`define SAP_REG_BUCKET 8'h0C
`define SAP_REG_CHAN 8'h10
`define SAP_REG_RECLEN 8'h14
`define SAP_REG_STAT 8'h18
`define SAP_CTRL_RST 8'h00
`define SAP_CTRL_ET_BIT 2
`define SAP_CTRL_CONT_BIT 3
`define SAP_CTRL_XY_BIT 4
`define SAP_CTRL_XYREF_BIT 5
`define SAP_CTRL_SHORT_BIT 6
`define SAP_CTRL_SINGLE_BIT 7
`define SAP_AVG_LOG2_MIN 4'h1
`define SAP_AVG_LOG2_MAX 4'h8
`define SAP_CUTOFF_MAX 6'h31
`define SAP_BUCKET_RST 8'h10
`define SAP_CHAN_RST 8'h01
`define SAP_LEN_2M 22'd2000000
`define SAP_LEN_1M 22'd1000000
`define SAP_LEN_500K 22'd500000
`define SAP_AVG_DEPTH 256
`define SAP_FIFO_DEPTH 32
`define SAP_FIFO_MARGIN 6'h04
`define SAP_FILT_FRAC 8
`define SAP_FILT_SHIFT 7
`endif

// >>> shared/sap_pkg.sv
// Types shared by the acquisition core and its output buffer
package sap_pkg;
	typedef enum logic [1:0] {SAP_MODE_SAMPLE, SAP_MODE_MINMAX,
		SAP_MODE_AVERAGE} sap_mode_e;
	typedef enum logic [1:0] {SAP_KIND_PLAIN, SAP_KIND_MINMAX, SAP_KIND_AVG,
		SAP_KIND_ET} sap_kind_e;
	typedef struct packed {
		logic [3:0][7:0] ch;
	} sap_samples_s;
	typedef struct packed {
		logic [7:0] x1;
		logic [7:0] y1;
		logic [7:0] x2;
		logic [7:0] y2;
	} sap_xy_s;
	typedef struct packed {
		sap_kind_e kind;
		logic [7:0] a;
		logic [7:0] b;
		logic [11:0] slot;
	} sap_word_s;
endpackage

// >>> core/sap_fifo.sv
// Synchronous FIFO with registered output stage
`timescale 1ns/1ps
`default_nettype none
module sap_fifo
	import sap_pkg::*;
#(
	parameter int WIDTH = 30,
	parameter int DEPTH = 32
)
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in,
	output logic [$clog2(DEPTH):0] level_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready_out = (count_q != AW'(0) + (AW+1)'(DEPTH));
	assign push = in_valid_in && in_ready_out;
	assign pop = (count_q != '0) && (!out_valid_out || out_ready_in);
	assign level_out = count_q;

	////////////////////////////////////////////////////////////////////////
	// Storage
	always_ff @(posedge sys_clk_in)
	begin
		if (clk_en_in && push)
		begin
			mem[wptr_q] <= in_data_in;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
		end
		else if (clk_en_in)
		begin
			if (push)
				wptr_q <= wptr_q + AW'(1);
			if (pop)
				rptr_q <= rptr_q + AW'(1);
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output register
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end
		else if (clk_en_in)
		begin
			if (pop)
			begin
				out_valid_out <= 1'b1;
				out_data_out <= mem[rptr_q];
			end
			else if (out_ready_in)
				out_valid_out <= 1'b0;
		end
	end
endmodule // sap_fifo
`default_nettype wire

// >>> core/sap_core.sv
// Acquisition post-processing core: modes, filter, X-Y, reconstruction
// Function
// RL1 - Reset mode is plain sampling, samples unaltered
// RL2 - Min/max mode outputs min, max per bucket
// RL3 - Averaging over 2 to 256 acquisitions
// RL4 - Filter only continuous, sample or min/max
// RL5 - Cutoff in 1% steps, up to 49%
// RL6 - Cutoff zero disables filter
// RL7 - X-Y: inputs one/two, three/four pairs
// RL8 - Stored traces pair the same way
// RL9 - Controller enables X-Y with pair active
// RL10 - Time-domain record continues during X-Y
// RL11 - Equivalent-time merges repeated acquisitions
// RL12 - Sinc mode interpolates between real samples
// RL13 - Short setting fixes length at 1M
// RL14 - Auto setting picks largest allowed length
// RL15 - No full pair: 2M single, 1M else
// RL16 - Full pair: 1M single, 500k else
// RL17 - Average is sum shifted by log2 count
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"
module sap_core
	import sap_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [`SAP_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	input wire sap_samples_s samples_in,
	input wire logic samples_valid_in,
	input wire logic acq_start_in,
	input wire logic [2:0] et_phase_in,
	input wire sap_samples_s stored_traces_in,
	output logic samples_ready_out,
	output sap_xy_s xy_out,
	output logic xy_valid_out,
	output logic word_valid_out,
	output sap_word_s word_out,
	input wire logic word_ready_in
);
	logic [7:0] ctrl_q;
	logic [3:0] avg_log2_q;
	logic [5:0] cutoff_q;
	logic [7:0] bucket_q;
	logic [7:0] chan_q;
	logic [21:0] reclen_q;
	sap_mode_e mode;
	logic [7:0] x;
	logic [7:0] filt_x;
	logic [15:0] filt_q;
	logic [7:0] h0_q;
	logic [7:0] h1_q;
	logic [7:0] h2_q;
	logic [21:0] idx_q;
	logic [7:0] bcnt_q;
	logic [7:0] min_q;
	logic [7:0] max_q;
	logic [8:0] acq_q;
	logic [15:0] acc [`SAP_AVG_DEPTH];
	logic push_q;
	sap_word_s push_word_q;
	logic fifo_ready;
	logic [5:0] fifo_level;
	logic filt_on;
	logic pair_full;
	logic take;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [7:0] sat8(input logic signed [15:0] v);
		if (v < 16'sh0000)
			return 8'h00;
		else if (v > 16'sh00FF)
			return 8'hFF;
		else
			return v[7:0];
	endfunction

	function automatic logic [7:0] mean_shift(input logic [15:0] sum,
		input logic [3:0] sh);
		logic [15:0] r;
		r = sum >> sh;
		return r[7:0];
	endfunction

	assign mode = sap_mode_e'(ctrl_q[1:0]);
	assign x = samples_in.ch[chan_q[5:4]];
	assign take = clk_en_in && samples_valid_in && samples_ready_out;
	assign pair_full = (chan_q[0] && chan_q[1]) || (chan_q[2] && chan_q[3]);
	assign filt_on = ctrl_q[`SAP_CTRL_CONT_BIT] && (mode != SAP_MODE_AVERAGE)
		&& (cutoff_q != 6'h00); // RL4 RL6

	////////////////////////////////////////////////////////////////////////
	// Register writes
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			ctrl_q <= `SAP_CTRL_RST; // RL1
			avg_log2_q <= `SAP_AVG_LOG2_MIN;
			cutoff_q <= 6'h00;
			bucket_q <= `SAP_BUCKET_RST;
			chan_q <= `SAP_CHAN_RST;
		end
		else if (clk_en_in && reg_wr_in)
		begin
			case (reg_addr_in)
				`SAP_REG_CTRL:
				begin
					ctrl_q <= reg_wdata_in[7:0];
					if (reg_wdata_in[1:0] == 2'h3)
						ctrl_q[1:0] <= SAP_MODE_SAMPLE;
				end
				`SAP_REG_AVG:
				begin
					if (reg_wdata_in[3:0] < `SAP_AVG_LOG2_MIN)
						avg_log2_q <= `SAP_AVG_LOG2_MIN; // RL3
					else if (reg_wdata_in[3:0] > `SAP_AVG_LOG2_MAX)
						avg_log2_q <= `SAP_AVG_LOG2_MAX; // RL3
					else
						avg_log2_q <= reg_wdata_in[3:0];
				end
				`SAP_REG_CUTOFF:
				begin
					if (reg_wdata_in[5:0] > `SAP_CUTOFF_MAX)
						cutoff_q <= `SAP_CUTOFF_MAX; // RL5
					else
						cutoff_q <= reg_wdata_in[5:0];
				end
				`SAP_REG_BUCKET:
				begin
					if (reg_wdata_in[7:0] == 8'h00)
						bucket_q <= 8'h01;
					else
						bucket_q <= reg_wdata_in[7:0];
				end
				`SAP_REG_CHAN: chan_q <= {2'h0, reg_wdata_in[5:0]};
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register reads, data one cycle later
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			reg_rdata_out <= 32'h00000000;
		else if (clk_en_in)
		begin
			reg_rdata_out <= 32'h00000000;
			if (reg_rd_in)
			begin
				case (reg_addr_in)
					`SAP_REG_CTRL: reg_rdata_out <= {24'h000000, ctrl_q};
					`SAP_REG_AVG: reg_rdata_out <= {28'h0000000, avg_log2_q};
					`SAP_REG_CUTOFF: reg_rdata_out <= {26'h0000000, cutoff_q};
					`SAP_REG_BUCKET: reg_rdata_out <= {24'h000000, bucket_q};
					`SAP_REG_CHAN: reg_rdata_out <= {24'h000000, chan_q};
					`SAP_REG_RECLEN: reg_rdata_out <= {10'h000, reclen_q};
					`SAP_REG_STAT: reg_rdata_out <= {17'h00000, fifo_level,
						acq_q};
					default: reg_rdata_out <= 32'h00000000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Record length selection
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			reclen_q <= `SAP_LEN_1M;
		else if (clk_en_in)
		begin
			if (ctrl_q[`SAP_CTRL_SHORT_BIT])
				reclen_q <= `SAP_LEN_1M; // RL13
			else if (!pair_full) // RL14
				reclen_q <= ctrl_q[`SAP_CTRL_SINGLE_BIT] ?
					`SAP_LEN_2M : `SAP_LEN_1M; // RL15
			else
				reclen_q <= ctrl_q[`SAP_CTRL_SINGLE_BIT] ?
					`SAP_LEN_1M : `SAP_LEN_500K; // RL16
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Low-pass filter, alpha = cutoff percent / 64
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			filt_q <= 16'h0000;
		else if (take)
		begin
			if (filt_on)
				filt_q <= filt_q + 16'((25'(signed'({1'b0, x,
					8'h00}) - signed'({1'b0, filt_q})) *
					signed'({1'b0, cutoff_q, 1'b0})) >>>
					`SAP_FILT_SHIFT); // RL5
			else
				filt_q <= {x, 8'h00}; // RL6
		end
	end

	assign filt_x = filt_on ? filt_q[15:`SAP_FILT_FRAC] : x; // RL4

	////////////////////////////////////////////////////////////////////////
	// X-Y pairing, time-domain path continues alongside
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			xy_out <= '0;
			xy_valid_out <= 1'b0;
		end
		else if (clk_en_in)
		begin
			xy_valid_out <= take && ctrl_q[`SAP_CTRL_XY_BIT]; // RL9
			if (take && ctrl_q[`SAP_CTRL_XY_BIT])
			begin
				if (ctrl_q[`SAP_CTRL_XYREF_BIT])
					xy_out <= {stored_traces_in.ch[0],
						stored_traces_in.ch[1], stored_traces_in.ch[2],
						stored_traces_in.ch[3]}; // RL8
				else
					xy_out <= {samples_in.ch[0], samples_in.ch[1],
						samples_in.ch[2], samples_in.ch[3]}; // RL7
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sample index and acquisition counter
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			idx_q <= '0;
			acq_q <= '0;
		end
		else if (clk_en_in)
		begin
			if (acq_start_in)
			begin
				idx_q <= '0;
				if (acq_q + 9'h001 >= (9'h001 << avg_log2_q))
					acq_q <= '0;
				else
					acq_q <= acq_q + 9'h001;
			end
			else if (take && idx_q < reclen_q - 22'h000001)
				idx_q <= idx_q + 22'h000001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// History for interpolation
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			h0_q <= 8'h00;
			h1_q <= 8'h00;
			h2_q <= 8'h00;
		end
		else if (take)
		begin
			h0_q <= h1_q;
			h1_q <= h2_q;
			h2_q <= filt_x;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bucket min/max tracking
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in || (clk_en_in && acq_start_in))
		begin
			bcnt_q <= 8'h00;
			min_q <= 8'hFF;
			max_q <= 8'h00;
		end
		else if (take && mode == SAP_MODE_MINMAX)
		begin
			if (bcnt_q + 8'h01 >= bucket_q)
			begin
				bcnt_q <= 8'h00;
				min_q <= 8'hFF;
				max_q <= 8'h00;
			end
			else
			begin
				bcnt_q <= bcnt_q + 8'h01;
				min_q <= (filt_x < min_q) ? filt_x : min_q;
				max_q <= (filt_x > max_q) ? filt_x : max_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Averaging accumulator
	always_ff @(posedge sys_clk_in)
	begin
		if (take && mode == SAP_MODE_AVERAGE)
		begin
			if (acq_q == 9'h000)
				acc[idx_q[7:0]] <= {8'h00, x};
			else
				acc[idx_q[7:0]] <= acc[idx_q[7:0]] + {8'h00, x}; // RL3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output word formation
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
		begin
			push_q <= 1'b0;
			push_word_q <= '0;
		end
		else if (clk_en_in)
		begin
			push_q <= 1'b0;
			if (take)
			begin
				push_word_q.slot <= idx_q[11:0];
				case (mode)
					SAP_MODE_SAMPLE:
					begin
						push_q <= 1'b1; // RL1 RL10
						push_word_q.a <= filt_x;
						if (ctrl_q[`SAP_CTRL_ET_BIT])
						begin
							push_word_q.kind <= SAP_KIND_ET;
							push_word_q.b <= 8'h00;
							push_word_q.slot <= {idx_q[8:0],
								et_phase_in}; // RL11
						end
						else
						begin
							push_word_q.kind <= SAP_KIND_PLAIN;
							push_word_q.b <= sat8((16'sd9 * signed'({8'h00,
								h1_q}) + 16'sd9 * signed'({8'h00, h2_q})
								- signed'({8'h00, h0_q})
								- signed'({8'h00, filt_x})) >>> 4); // RL12
						end
					end
					SAP_MODE_MINMAX:
					begin
						push_q <= (bcnt_q + 8'h01 >= bucket_q); // RL2
						push_word_q.kind <= SAP_KIND_MINMAX;
						push_word_q.a <= (filt_x < min_q) ? filt_x : min_q;
						push_word_q.b <= (filt_x > max_q) ? filt_x : max_q;
					end
					SAP_MODE_AVERAGE:
					begin
						push_q <= (acq_q + 9'h001 ==
							(9'h001 << avg_log2_q)); // RL3
						push_word_q.kind <= SAP_KIND_AVG;
						push_word_q.a <= mean_shift(acc[idx_q[7:0]] +
							{8'h00, x}, avg_log2_q); // RL17
						push_word_q.b <= 8'h00;
					end
					default: push_q <= 1'b0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Back-pressure to the converters
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			samples_ready_out <= 1'b0;
		else if (clk_en_in)
			samples_ready_out <= fifo_level <
				6'(`SAP_FIFO_DEPTH) - `SAP_FIFO_MARGIN;
	end

	sap_fifo #(
		.WIDTH($bits(sap_word_s)),
		.DEPTH(`SAP_FIFO_DEPTH)
	) u_fifo (
		.sys_clk_in(sys_clk_in),
		.reset_in(reset_in),
		.clk_en_in(clk_en_in),
		.in_valid_in(push_q),
		.in_data_in(push_word_q),
		.in_ready_out(fifo_ready),
		.out_valid_out(word_valid_out),
		.out_data_out(word_out),
		.out_ready_in(word_ready_in),
		.level_out(fifo_level)
	);
endmodule // sap_core
`default_nettype wire

// >>> dv/sap_core_chk.sv
// Port checks for the acquisition core
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"
module sap_core_chk
	import sap_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [`SAP_ADDR_W-1:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire sap_samples_s samples_in,
	input wire logic samples_valid_in,
	input wire sap_samples_s stored_traces_in,
	input wire logic samples_ready_out,
	input wire sap_xy_s xy_out,
	input wire logic xy_valid_out
);
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (reset_in);
	logic [7:0] ctrl_q;
	logic [3:0] chan_q;
	logic pair;
	logic take;
	logic wr_ok;
	assign wr_ok = reg_wr_in & clk_en_in;
	assign pair = &chan_q[1:0] | &chan_q[3:2];
	assign take = samples_valid_in & samples_ready_out & clk_en_in;
	////////////////////////////////
	// Shadow of control register
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			ctrl_q <= `SAP_CTRL_RST;
		else if (wr_ok && reg_addr_in == `SAP_REG_CTRL)
			ctrl_q <= {reg_wdata_in[7:2],
				reg_wdata_in[1:0] == 2'h3 ? 2'h0 : reg_wdata_in[1:0]};
	end
	// Shadow of active inputs
	always_ff @(posedge sys_clk_in)
	begin
		if (reset_in)
			chan_q <= `SAP_CHAN_RST;
		else if (wr_ok && reg_addr_in == `SAP_REG_CHAN)
			chan_q <= reg_wdata_in[3:0];
	end
	////////////////////////////////
	sequence rd_at(logic [7:0] a);
		reg_rd_in && clk_en_in && reg_addr_in == a;
	endsequence
	sequence len_rd;
		rd_at(`SAP_REG_RECLEN) ##0 !ctrl_q[`SAP_CTRL_SHORT_BIT];
	endsequence
	sequence xy_take;
		take && ctrl_q[`SAP_CTRL_XY_BIT];
	endsequence
	chk_mode_read: assert property (
		rd_at(`SAP_REG_CTRL) |=> reg_rdata_out[1:0] == $past(ctrl_q[1:0]))
		else $error("mode readback wrong");
	chk_avg_range: assert property (
		rd_at(`SAP_REG_AVG) |=> reg_rdata_out inside {[1:8]})
		else $error("average count out of range");
	chk_cutoff_cap: assert property (
		rd_at(`SAP_REG_CUTOFF) |=> reg_rdata_out <= 32'h31)
		else $error("cutoff above cap");
	chk_len_short: assert property (
		rd_at(`SAP_REG_RECLEN) ##0 ctrl_q[`SAP_CTRL_SHORT_BIT]
		|=> reg_rdata_out == `SAP_LEN_1M)
		else $error("short length wrong");
	chk_len_single: assert property (
		len_rd ##0 ctrl_q[`SAP_CTRL_SINGLE_BIT] |=> reg_rdata_out ==
		($past(pair) ? `SAP_LEN_1M : `SAP_LEN_2M))
		else $error("single length wrong");
	chk_len_normal: assert property (
		len_rd ##0 !ctrl_q[`SAP_CTRL_SINGLE_BIT] |=> reg_rdata_out ==
		($past(pair) ? `SAP_LEN_500K : `SAP_LEN_1M))
		else $error("normal length wrong");
	chk_xy_live: assert property (
		xy_take ##0 !ctrl_q[`SAP_CTRL_XYREF_BIT] |=> xy_valid_out
		&& xy_out == {$past(samples_in.ch[0]), $past(samples_in.ch[1]),
		$past(samples_in.ch[2]), $past(samples_in.ch[3])})
		else $error("live pair wrong");
	chk_xy_ref: assert property (
		xy_take ##0 ctrl_q[`SAP_CTRL_XYREF_BIT] |=> xy_valid_out
		&& xy_out == {$past(stored_traces_in.ch[0]),
		$past(stored_traces_in.ch[1]), $past(stored_traces_in.ch[2]),
		$past(stored_traces_in.ch[3])})
		else $error("stored pair wrong");
	chk_xy_quiet: assert property (
		!take |=> !xy_valid_out)
		else $error("pair output without sample");
endmodule // sap_core_chk
bind sap_core sap_core_chk u_chk (.sys_clk_in, .reset_in, .clk_en_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.samples_in, .samples_valid_in, .stored_traces_in, .samples_ready_out,
	.xy_out, .xy_valid_out);
`default_nettype wire

// >>> dv/sap_adc_model.sv
// Converter model offering one sample set per request
`timescale 1ns/1ps
`default_nettype none
module sap_adc_model
	import sap_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic ready_in,
	output var sap_samples_s samples_out,
	output var logic valid_out
);
	initial
	begin
		samples_out = '0;
		valid_out = 1'b0;
	end
	// Hold the set until taken or for 40 cycles, then drop and invert the lines
	task automatic put(input sap_samples_s s, output bit ok);
		ok = 0;
		@(posedge sys_clk_in);
		samples_out <= s;
		valid_out <= 1'b1;
		for (int n = 0; n < 40 && !ok; n++)
		begin
			@(posedge sys_clk_in);
			ok = ready_in;
		end
		valid_out <= 1'b0;
		samples_out <= ~s;
	endtask
endmodule // sap_adc_model
`default_nettype wire

// >>> dv/testbench.sv
// Self-checking bench for the acquisition core
`timescale 1ns/1ps
`default_nettype none
`include "sap_consts.svh"
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module testbench
	import sap_pkg::*;
;
	logic sys_clk_in = 0;
	logic reset_in = 1;
	logic [7:0] reg_addr_in = 0;
	logic [31:0] reg_wdata_in = 0;
	logic reg_wr_in = 0;
	logic reg_rd_in = 0;
	logic acq_start_in = 0;
	logic [2:0] et_phase_in = 0;
	logic word_ready_in = 0;
	sap_samples_s stored_traces_in = 0;
	sap_samples_s samples_in;
	logic samples_valid_in;
	logic samples_ready_out;
	logic xy_valid_out;
	logic word_valid_out;
	logic [31:0] reg_rdata_out;
	sap_xy_s xy_out;
	sap_word_s word_out;
	sap_word_s e;
	sap_word_s exp_q[$];
	logic [1:0] msk_q[$];
	logic [1:0] m;
	int errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int seed = 32'hAAF1;
	int src = 0;
	int idx = 0;
	int hist[3] = '{0, 0, 0};
	int sb = 0;
	bit stall = 0;
	sap_core u_dut (.sys_clk_in, .reset_in, .clk_en_in(1'b1), .reg_addr_in,
		.reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .samples_in,
		.samples_valid_in, .acq_start_in, .et_phase_in, .stored_traces_in,
		.samples_ready_out, .xy_out, .xy_valid_out, .word_valid_out,
		.word_out, .word_ready_in);
	sap_adc_model u_adc (.sys_clk_in, .ready_in(samples_ready_out),
		.samples_out(samples_in), .valid_out(samples_valid_in));
	initial
		forever #4 sys_clk_in = ~sys_clk_in;
	////////////////////////////////
	task automatic check(string nm, logic [31:0] x, logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, x, g);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, output logic [31:0] d);
		@(posedge sys_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		reg_rd_in <= 1'b0;
		#1;
		d = reg_rdata_out;
	endtask
	task automatic acq();
		@(posedge sys_clk_in);
		acq_start_in <= 1'b1;
		et_phase_in <= 3'($random(seed));
		@(posedge sys_clk_in);
		acq_start_in <= 1'b0;
		idx = 0;
	endtask
	// One sample set; plain and ET words are expected at once
	// Plain words carry an interpolation from the three previous samples and the new one
	task automatic samp(sap_kind_e k, int ov, output logic [7:0] v);
		sap_samples_s s;
		bit ok;
		s = $random(seed);
		if (ov >= 0)
			s.ch[src] = ov[7:0];
		u_adc.put(s, ok);
		v = s.ch[src];
		sb = (9 * hist[1] + 9 * hist[2] - hist[0] - int'(v)) >>> 4;
		sb = sb < 0 ? 0 : sb > 255 ? 255 : sb;
		if (ok && k inside {SAP_KIND_PLAIN, SAP_KIND_ET})
		begin
			exp_q.push_back('{k, v, 8'(sb), {idx[8:0], et_phase_in}});
			msk_q.push_back({k == SAP_KIND_ET, k == SAP_KIND_PLAIN});
		end
		if (ok)
		begin
			hist[0] = hist[1];
			hist[1] = hist[2];
			hist[2] = int'(v);
		end
		idx += ok;
	endtask
	////////////////////////////////
	// Sink with random stalls, compared with the expected words
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc > 40000)
		begin
			errors++;
			close_out();
		end
		word_ready_in <= !stall && $random(seed) % 4 != 0;
		stored_traces_in <= $random(seed);
		if (!reset_in && word_valid_out && word_ready_in)
		begin
			`CHK("word expected", 1, exp_q.size() > 0);
			e = exp_q.pop_front();
			m = msk_q.pop_front();
			`CHK("kind", e.kind, word_out.kind);
			`CHK("value", e.a, word_out.a);
			if (m[0])
				`CHK("second", e.b, word_out.b);
			if (m[1])
				`CHK("slot", e.slot, word_out.slot);
		end
	end
	initial
	begin
		logic [31:0] d;
		logic [7:0] v;
		logic [7:0] mn;
		logic [7:0] mx;
		int p;
		repeat (3) @(posedge sys_clk_in);
		reset_in <= 1'b0;
		rd(`SAP_REG_CTRL, d);
		`CHK("ctrl reset", 0, d);
		rd(8'h1C, d);
		`CHK("unmapped", 0, d);
		wr(`SAP_REG_CTRL, 32'h3);
		rd(`SAP_REG_CTRL, d);
		`CHK("mode three", 0, d);
		for (int i = 0; i < 10; i++)
		begin
			wr(`SAP_REG_AVG, i);
			rd(`SAP_REG_AVG, d);
			`CHK("avg", i < 1 ? 1 : i > 8 ? 8 : i, d);
		end
		for (int i = 0; i < 64; i += 7)
		begin
			wr(`SAP_REG_CUTOFF, i);
			rd(`SAP_REG_CUTOFF, d);
			`CHK("cutoff", i > 49 ? 49 : i, d);
		end
		for (int i = 1; i < 64; i++)
		begin
			wr(`SAP_REG_CHAN, i[3:0]);
			wr(`SAP_REG_CTRL, {i[5:4], 6'h0});
			rd(`SAP_REG_RECLEN, d);
			p = (i[0] & i[1]) | (i[2] & i[3]);
			`CHK("reclen", i[4] ? 1000000 : i[5] ? (p ? 1000000 : 2000000)
				: (p ? 500000 : 1000000), d);
		end
		wr(`SAP_REG_CHAN, 32'h2F);
		src = 2;
		// Averaging: alternating levels, mean lands between them
		wr(`SAP_REG_AVG, 1);
		wr(`SAP_REG_CUTOFF, 20);
		wr(`SAP_REG_CTRL, 32'h0A);
		// Group counter starts ahead of the first start; align to a group
		acq();
		p = {$random(seed)} % 250;
		for (int j = 0; j < 4; j++)
		begin
			acq();
			for (int i = 0; i < 3; i++)
			begin
				samp(SAP_KIND_AVG, p + i + 2 * (j % 2), v);
				if (j % 2)
				begin
					exp_q.push_back('{SAP_KIND_AVG, 8'(p + i + 1), 8'h0, 12'h0});
					msk_q.push_back(2'h0);
				end
			end
		end
		// Plain samples with X-Y on, buffer filled while the sink stalls
		wr(`SAP_REG_CUTOFF, 0);
		wr(`SAP_REG_CTRL, 32'h18);
		acq();
		stall = 1;
		for (int i = 0; i < 34; i++)
			samp(SAP_KIND_PLAIN, -1, v);
		`CHK("full", 0, samples_ready_out);
		stall = 0;
		wr(`SAP_REG_CUTOFF, 20);
		wr(`SAP_REG_CTRL, 32'h30);
		for (int i = 0; i < 8; i++)
			samp(SAP_KIND_PLAIN, -1, v);
		wr(`SAP_REG_CTRL, 32'h04);
		acq();
		for (int i = 0; i < 8; i++)
			samp(SAP_KIND_ET, -1, v);
		// Min/max over buckets of four
		wr(`SAP_REG_BUCKET, 4);
		wr(`SAP_REG_CUTOFF, 0);
		wr(`SAP_REG_CTRL, 32'h09);
		acq();
		for (int i = 0; i < 12; i++)
		begin
			samp(SAP_KIND_MINMAX, -1, v);
			mn = (i % 4 == 0 || v < mn) ? v : mn;
			mx = (i % 4 == 0 || v > mx) ? v : mx;
			if (i % 4 == 3)
			begin
				exp_q.push_back('{SAP_KIND_MINMAX, mn, mx, 12'h0});
				msk_q.push_back(2'h1);
			end
		end
		for (int i = 0; i < 500 && exp_q.size() > 0; i++)
			@(posedge sys_clk_in);
		`CHK("drained", 0, exp_q.size());
		`CHK("ready again", 1, samples_ready_out);
		close_out();
	end
endmodule // testbench
`default_nettype wire
